// file: src/cfbf_front_end.sv
/*
  One quadrant of the correlator band-mode front end: Walsh removal, the
  wideband 2-bit bypass with self and cross products, and the narrowband
  path of tuned, averaged spectral windows on both polarisations.
  Assumes samples, Walsh states and configuration arrive on clk_sys.
*/
// Functional notes
// - a quadrant takes one 2 GHz dual-polarisation baseband, up to 64 antennas.
// - wideband mode bypasses the tunable filter bank entirely.
// - wideband mode drops each sample's least significant bit, 3 to 2 bits.
// - wideband gives one window of 256 channels over polarisation product count.
// - polarisation products are two (parallel hands) or four (full).
// - narrowband mode filters and mixes each stream with a tuning oscillator.
// - each filter bank has 32 sub-bands of 62.5 MHz.
// - sub-bands overlap; fifteen sixteenths, 58.59375 MHz, are usable.
// - joined sub-bands give up to 15/16 of 8192 channels over product count.
// - adjacent channels may be averaged by 2, 4, 8 or 16.
// - a window uses 32, 16, 8, 4, 2 or 1 sub-bands.
// - up to four spectral windows per baseband in narrowband mode.
// - windows of one baseband share channel spacing; basebands independent.
// - tuning oscillator moves window centres in 30.5 kHz steps.
// - tuning keeps every selected sub-band wholly inside the baseband.
// - remove 90 and 180 degree Walsh switching from incoming data.
// - self and cross products are formed together from the same data.
// - logic runs on 32 parallel lanes of the demultiplexed stream.
// - each quadrant chooses wideband or narrowband on its own.
// - narrowband holds at most 8192 points per baseband per polarisation.
`include "cfbf_defines.svh"
module cfbf_front_end
  import cfbf_pkg::*;
#(
  parameter int LANES = 32,
  parameter int ACC_W = `CFBF_ACC_W
)(
  // clock, reset, enable
  input  wire logic                                  clk_sys,
  input  wire logic                                  srst,
  input  wire logic                                  ce,
  // one dual-polarisation baseband
  // baseband sample lanes, two polarisations
  input  wire logic [LANES*`CFBF_SMP_W-1:0]          smp_x,
  input  wire logic [LANES*`CFBF_SMP_W-1:0]          smp_y,
  input  wire logic                                  smp_valid,
  // Walsh switching states
  input  wire logic                                  walsh_90,
  input  wire logic                                  walsh_180,
  // requested configuration
  input  wire logic                                  cfg_narrowband,
  input  wire logic                                  cfg_full_pol,
  input  wire logic [2:0]                            cfg_nsub_log2,
  input  wire logic [2:0]                            cfg_avg_log2,
  input  wire logic [`CFBF_NSPW-1:0]                 cfg_spw_en,
  input  wire logic [`CFBF_NSPW*`CFBF_TUNE_W-1:0]    cfg_tune,
  input  wire logic                                  int_boundary,
  // wideband output
  output logic [LANES*`CFBF_WB_W-1:0]                wb_x,
  output logic [LANES*`CFBF_WB_W-1:0]                wb_y,
  output logic                                       wb_valid,
  output logic [$clog2(9*LANES+1):0]                 prod_auto_x,
  output logic [$clog2(9*LANES+1):0]                 prod_auto_y,
  output logic signed [$clog2(9*LANES+1):0]          prod_cross,
  // narrowband output, window k polarisation p at index 2k+p
  output logic [2*`CFBF_NSPW*ACC_W-1:0]              nb_data,
  output logic [2*`CFBF_NSPW-1:0]                    nb_valid,
  // status
  output logic                                       act_narrowband,
  output logic [12:0]                                act_chans,
  output logic                                       cfg_err
);

  localparam int PW = $clog2(9*LANES+1)+1;
  localparam int NCH = 2*`CFBF_NSPW;

  typedef struct packed {
    cfbf_cfg_t                cfg;
    logic                     err;
    logic [12:0]              chans;
    logic [LANES*2-1:0]       wbx;
    logic [LANES*2-1:0]       wby;
    logic                     wbv;
    logic [PW-1:0]            ax;
    logic [PW-1:0]            ay;
    logic signed [PW-1:0]     xp;
    logic [NCH*ACC_W-1:0]     nbd;
    logic [NCH-1:0]           nbv;
  } cfbf_st_t;

  cfbf_st_t s_q;
  cfbf_st_t s_d;

  logic [LANES*3-1:0]         dem_x;
  logic [LANES*3-1:0]         dem_y;
  logic [NCH*ACC_W-1:0]       ch_data;
  logic [NCH-1:0]             ch_valid;

  // ==========================================================================
  // helpers
  function automatic logic tune_ok(input logic [`CFBF_TUNE_W-1:0] t, input logic [2:0] nsub_log2);
    logic [16:0] half;
    half = `CFBF_SUB_HALF_TUNE << nsub_log2;
    return ({1'b0, t} >= half) && (({1'b0, t} + half) <= `CFBF_TUNE_SPAN);
  endfunction : tune_ok

  function automatic logic [12:0] chan_count(input logic nb, input logic full_pol,
                                             input logic [2:0] nsub_log2, input logic [2:0] avg_log2);
    logic [12:0] n;
    if (!nb) begin
      n = `CFBF_WB_CHANS >> (full_pol ? 2 : 1);
    end else begin
      n = 13'(`CFBF_NB_USABLE) >> (full_pol ? 2 : 1);
      n = n >> (`CFBF_NSUB_MAX_LOG2 - nsub_log2);
      n = n >> avg_log2;
    end
    return n;
  endfunction : chan_count

  // 2-bit code c stands for 2c-3
  function automatic logic signed [2:0] lvl2(input logic [1:0] c);
    return $signed({1'b0, c}) * 3'sh2 - 3'sh3;
  endfunction : lvl2

  // ==========================================================================
  // Walsh removal
  // demodulation: level inversion is bitwise complement
  assign dem_x = smp_x ^ {(LANES*3){walsh_180}};
  assign dem_y = smp_y ^ {(LANES*3){walsh_180 ^ walsh_90}};

  // ==========================================================================
  // narrowband channels
  // four windows, two polarisations each
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    cfbf_spw_if #(.LANES(LANES), .ACC_W(ACC_W)) spw ();
    // one averaging factor for all windows
    assign spw.avg_log2  = s_q.cfg.avg_log2;
    assign spw.tune      = s_q.cfg.tune[(g/2)*`CFBF_TUNE_W +: `CFBF_TUNE_W];
    assign spw.en        = (s_q.cfg.mode == CFBF_NARROWBAND) && s_q.cfg.spw_en[g/2];
    assign spw.smp       = (g % 2 == 1) ? dem_y : dem_x;
    assign spw.smp_valid = smp_valid;
    assign ch_data[g*ACC_W +: ACC_W] = spw.data;
    assign ch_valid[g]               = spw.valid;
    cfbf_spw_chan #(.LANES(LANES), .ACC_W(ACC_W)) u_chan (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .c       (spw.chan)
    );
  end

  // ==========================================================================
  // datapath and configuration
  always_comb begin
    logic        bad;
    logic [PW-1:0] ax;
    logic [PW-1:0] ay;
    logic signed [PW-1:0] xp;
    logic signed [2:0] lx;
    logic signed [2:0] ly;
    bad = 1'b0;
    ax  = '0;
    ay  = '0;
    xp  = '0;
    lx  = '0;
    ly  = '0;
    s_d = s_q;
    s_d.wbv = 1'b0;
    s_d.nbv = '0;

    unique case (s_q.cfg.mode)
      CFBF_WIDEBAND: begin
        if (smp_valid) begin
          s_d.wbv = 1'b1;
          for (int i = 0; i < LANES; i++) begin
            s_d.wbx[2*i +: 2] = dem_x[3*i+1 +: 2];
            s_d.wby[2*i +: 2] = dem_y[3*i+1 +: 2];
            lx = lvl2(dem_x[3*i+1 +: 2]);
            ly = lvl2(dem_y[3*i+1 +: 2]);
            ax = ax + PW'(lx * lx);
            ay = ay + PW'(ly * ly);
            xp = xp + PW'(lx * ly);
          end
          s_d.ax = ax;
          s_d.ay = ay;
          s_d.xp = xp;
        end
      end
      CFBF_NARROWBAND: begin
        s_d.nbd = ch_data;
        s_d.nbv = ch_valid;
      end
    endcase

    if (int_boundary) begin
      if (cfg_narrowband) begin
        bad = (cfg_nsub_log2 > `CFBF_NSUB_MAX_LOG2) || (cfg_avg_log2 > `CFBF_AVG_MAX_LOG2);
        for (int k = 0; k < `CFBF_NSPW; k++) begin
          if (cfg_spw_en[k] && !tune_ok(cfg_tune[k*`CFBF_TUNE_W +: `CFBF_TUNE_W], cfg_nsub_log2)) begin
            bad = 1'b1;
          end
        end
      end
      s_d.err = bad;
      if (!bad) begin
        s_d.cfg.mode      = cfg_narrowband ? CFBF_NARROWBAND : CFBF_WIDEBAND;
        s_d.cfg.full_pol  = cfg_full_pol;
        s_d.cfg.nsub_log2 = cfg_nsub_log2;
        s_d.cfg.avg_log2  = cfg_avg_log2;
        s_d.cfg.spw_en    = cfg_spw_en;
        s_d.cfg.tune      = cfg_tune;
        s_d.chans = chan_count(cfg_narrowband, cfg_full_pol, cfg_nsub_log2, cfg_avg_log2);
      end
    end
    // drop in-flight spectra
    // a pulse left over from narrowband would stand beside wideband mode
    if (s_d.cfg.mode == CFBF_WIDEBAND) begin
      s_d.nbv = '0;
    end
  end

  // reset leaves wideband, dual polarisation, no windows enabled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_x           = s_q.wbx;
  assign wb_y           = s_q.wby;
  assign wb_valid       = s_q.wbv;
  assign prod_auto_x    = s_q.ax;
  assign prod_auto_y    = s_q.ay;
  assign prod_cross     = s_q.xp;
  assign nb_data        = s_q.nbd;
  assign nb_valid       = s_q.nbv;
  assign act_narrowband = (s_q.cfg.mode == CFBF_NARROWBAND);
  assign act_chans      = s_q.chans;
  assign cfg_err        = s_q.err;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_wb_pass;
    (ce && smp_valid && !act_narrowband && !int_boundary ##1 ce) |-> wb_valid;
  endproperty
  a_wb_pass: assert property (p_wb_pass) else $error("wideband sample not passed");

  property p_trunc;
    (ce && smp_valid && !act_narrowband && !walsh_180 && !walsh_90 ##1 ce)
      |-> (wb_x[1:0] == $past(smp_x[2:1])) && (wb_y[1:0] == $past(smp_y[2:1]));
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation lost top bits");

  property p_walsh;
    (ce && smp_valid && !act_narrowband && walsh_180 && !walsh_90 ##1 ce)
      |-> wb_x[1:0] == ~$past(smp_x[2:1]);
  endproperty
  a_walsh: assert property (p_walsh) else $error("180 degree switching not removed");

  property p_hold;
    !int_boundary |=> $stable(act_narrowband) && $stable(act_chans) && $stable(s_q.cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed off boundary");

  property p_bad_tune;
    (ce && int_boundary && cfg_narrowband && cfg_spw_en[0] && cfg_nsub_log2 <= 3'd5
      && cfg_tune[15:0] < (16'h0400 << cfg_nsub_log2)) |=> cfg_err && $stable(s_q.cfg);
  endproperty
  a_bad_tune: assert property (p_bad_tune) else $error("out-of-band tuning accepted");

  property p_mode;
    (ce && int_boundary && !cfg_narrowband) |=> !act_narrowband && !cfg_err;
  endproperty
  a_mode: assert property (p_mode) else $error("wideband request not taken");

  property p_wb_chans;
    (ce && int_boundary && !cfg_narrowband) |=> act_chans == (cfg_full_pol ? 13'd64 : 13'd128);
  endproperty
  a_wb_chans: assert property (p_wb_chans) else $error("wideband channel count wrong");

  property p_nb_chans;
    (ce && int_boundary && cfg_narrowband && !cfg_full_pol && cfg_nsub_log2 == 3'd5
      && cfg_avg_log2 == 3'd0 && cfg_spw_en == 4'h0) |=> act_chans == 13'd3840;
  endproperty
  a_nb_chans: assert property (p_nb_chans) else $error("narrowband channel count wrong");

  property p_nb_only;
    (nb_valid != '0) |-> act_narrowband && (wb_valid == 1'b0);
  endproperty
  a_nb_only: assert property (p_nb_only) else $error("narrowband data in wideband mode");

  property p_walsh90;
    (ce && smp_valid && !act_narrowband && walsh_90 && !walsh_180 ##1 ce)
      |-> (wb_x[1:0] == $past(smp_x[2:1])) && (wb_y[1:0] == ~$past(smp_y[2:1]));
  endproperty
  a_walsh90: assert property (p_walsh90) else $error("90 degree switching not removed");

  // equal lanes on both polarisations turn the cross product into a self product
  property p_cross;
    (ce && smp_valid && !act_narrowband && (dem_x == dem_y) ##1 ce)
      |-> (prod_cross == $signed(prod_auto_x)) && (prod_auto_x == prod_auto_y);
  endproperty
  a_cross: assert property (p_cross) else $error("cross product differs from self product");

  property p_err_hold;
    !int_boundary |=> $stable(cfg_err);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag changed off boundary");

  property p_nb_silent;
    (ce && act_narrowband) |=> !wb_valid;
  endproperty
  a_nb_silent: assert property (p_nb_silent) else $error("wideband data in narrowband mode");

  property p_range;
    (ce && int_boundary && cfg_narrowband && ((cfg_nsub_log2 > 3'd5) || (cfg_avg_log2 > 3'd4)))
      |=> cfg_err && $stable(act_chans);
  endproperty
  a_range: assert property (p_range) else $error("out-of-range window shape accepted");

  c_wb_run:   cover property (wb_valid ##1 wb_valid);
  c_nb_out:   cover property (act_narrowband && nb_valid[0]);
  c_bad_cfg:  cover property (cfg_err);
  c_switch:   cover property (!act_narrowband ##1 act_narrowband);
  c_walsh90:  cover property (ce && smp_valid && walsh_90 && !act_narrowband);

endmodule : cfbf_front_end

// file: src/cfbf_defines.svh
/*
  Constants of the correlator band-mode front end: widths, channel counts and
  tuning limits. Included by the package users; holds definitions only.
*/
`ifndef CFBF_DEFINES_SVH
`define CFBF_DEFINES_SVH

// ==========================================================================
// sample formats
`define CFBF_SMP_W          3
`define CFBF_WB_W           2
`define CFBF_ACC_W          14

// ==========================================================================
// spectral layout
`define CFBF_NSPW           4
`define CFBF_NSUB_MAX_LOG2  3'd5
`define CFBF_AVG_MAX_LOG2   3'd4
`define CFBF_WB_CHANS       13'd256
`define CFBF_NB_POINTS      14'd8192
`define CFBF_NB_USABLE      (`CFBF_NB_POINTS - (`CFBF_NB_POINTS >> 4))

// ==========================================================================
// tuning: one step of the tuning word is 2 GHz / 65536, about 30.5 kHz
`define CFBF_TUNE_W         16
`define CFBF_SUB_HALF_TUNE  17'h00400
`define CFBF_TUNE_SPAN      17'h10000

`endif

// file: src/cfbf_pkg.sv
/*
  Types shared by the front end and its sub-band channel.
  Assumes cfbf_defines.svh is on the include path.
*/
`include "cfbf_defines.svh"
package cfbf_pkg;

  typedef enum logic {CFBF_WIDEBAND, CFBF_NARROWBAND} cfbf_mode_t;

  typedef struct packed {
    cfbf_mode_t                               mode;
    logic                                     full_pol;
    logic [2:0]                               nsub_log2;
    logic [2:0]                               avg_log2;
    logic [`CFBF_NSPW-1:0]                    spw_en;
    logic [`CFBF_NSPW*`CFBF_TUNE_W-1:0]       tune;
  } cfbf_cfg_t;

  // eight symmetric levels: code c stands for 2c-7
  function automatic logic signed [4:0] cfbf_smp_val(input logic [2:0] c);
    return $signed({1'b0, c, 1'b1}) - 5'sh08;
  endfunction : cfbf_smp_val

endpackage : cfbf_pkg

// file: src/cfbf_spw_if.sv
/*
  Link between the front end and one sub-band channel: tuning, averaging,
  the demodulated sample lanes and the averaged result.
  Assumes both ends run on the same clock.
*/
`include "cfbf_defines.svh"
interface cfbf_spw_if #(parameter int LANES = 32, parameter int ACC_W = `CFBF_ACC_W);
  logic [`CFBF_TUNE_W-1:0] tune;
  logic [2:0]              avg_log2;
  logic                    en;
  logic [LANES*3-1:0]      smp;
  logic                    smp_valid;
  logic signed [ACC_W-1:0] data;
  logic                    valid;

  modport top  (output tune, avg_log2, en, smp, smp_valid, input data, valid);
  modport chan (input tune, avg_log2, en, smp, smp_valid, output data, valid);
endinterface : cfbf_spw_if

// file: src/cfbf_spw_chan.sv
/*
  One tunable sub-band channel: NCO mixer over all lanes followed by a
  boxcar average of 2^avg_log2 cycles.
  Assumes the front end holds its controls stable between integration marks.
*/
`include "cfbf_defines.svh"
module cfbf_spw_chan
  import cfbf_pkg::*;
#(
  parameter int LANES = 32,
  parameter int ACC_W = `CFBF_ACC_W
)(
  // clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // channel link
  cfbf_spw_if.chan c
);

  typedef struct packed {
    logic [`CFBF_TUNE_W-1:0] phase;
    logic [4:0]              cnt;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] data;
    logic                    valid;
  } cfbf_chan_st_t;

  cfbf_chan_st_t s_q;
  cfbf_chan_st_t s_d;

  // ==========================================================================
  // mixer and averager
  always_comb begin
    logic signed [ACC_W-1:0]  sum;
    logic [`CFBF_TUNE_W-1:0]  lph;
    logic signed [ACC_W-1:0]  v;
    sum = '0;
    lph = '0;
    v   = '0;
    s_d = s_q;
    s_d.valid = 1'b0;
    if (!c.en) begin
      s_d = '0;
    end else if (c.smp_valid) begin
      for (int i = 0; i < LANES; i++) begin
        lph = s_q.phase + `CFBF_TUNE_W'(c.tune * i);
        v   = ACC_W'(cfbf_smp_val(c.smp[3*i +: 3]));
        // square-wave LO: cheap, at the cost of odd-harmonic images
        sum = lph[`CFBF_TUNE_W-1] ? sum - v : sum + v;
      end
      s_d.phase = s_q.phase + `CFBF_TUNE_W'(c.tune * LANES);
      s_d.acc   = (s_q.cnt == 5'h00) ? sum : s_q.acc + sum;
      if (s_q.cnt == 5'((5'h01 << c.avg_log2) - 5'h01)) begin
        s_d.data  = (s_q.cnt == 5'h00) ? sum : s_q.acc + sum;
        s_d.valid = 1'b1;
        s_d.cnt   = 5'h00;
      end else begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign c.data  = s_q.data;
  assign c.valid = s_q.valid;

endmodule : cfbf_spw_chan

// file: verif/cfbf_digitizer.sv
/*
  Behavioural digitizer link feeding one quadrant: while go is high every
  lane of both polarisations carries the commanded 3-bit code.
  Assumes the bench drives go and the codes at the rising edge of clk_sys.
*/
module cfbf_digitizer #(
  parameter int LANES = 32
)(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // command from the bench
  input  wire logic             go,
  input  wire logic [2:0]       cx,
  input  wire logic [2:0]       cy,
  // fibre side
  output logic [LANES*3-1:0]    smp_x,
  output logic [LANES*3-1:0]    smp_y,
  output logic                  smp_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // sample stream
  // eight levels, three bits
  always @(posedge clk_sys) begin
    if (srst) begin
      smp_valid <= 1'b0;
      smp_x     <= '0;
      smp_y     <= '0;
    end else if (go) begin
      smp_valid <= 1'b1;
      smp_x     <= {LANES{cx}};
      smp_y     <= {LANES{cy}};
    end else begin
      // idle lanes toggle so stale words can never pass for new ones
      smp_valid <= 1'b0;
      smp_x     <= ~smp_x;
      smp_y     <= ~smp_y;
    end
  end
endmodule : cfbf_digitizer

// file: verif/cfbf_front_end_tb.sv
/*
  Self-checking bench of one front-end quadrant: configuration at
  integration marks, wideband truncation and products, narrowband averaging.
  Assumes the digitizer model as sample source; clock enable drops once to check the freeze.
*/
module cfbf_front_end_tb;
  import cfbf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 32;

  // ==========================================================================
  // signals
  logic               clk_sys = 1'b0;
  logic               srst = 1'b1;
  logic               ce = 1'b1;
  logic               go = 1'b0;
  logic [2:0]         cx = 3'h0;
  logic [2:0]         cy = 3'h0;
  logic [LANES*3-1:0] smp_x, smp_y;
  logic               smp_valid;
  logic               walsh_90 = 1'b0;
  logic               walsh_180 = 1'b0;
  logic               cfg_narrowband = 1'b0;
  logic               cfg_full_pol = 1'b0;
  logic [2:0]         cfg_nsub_log2 = 3'h0;
  logic [2:0]         cfg_avg_log2 = 3'h0;
  logic [3:0]         cfg_spw_en = 4'h0;
  logic [63:0]        cfg_tune = 64'h0;
  logic               int_boundary = 1'b0;
  logic [63:0]        wb_x, wb_y;
  logic               wb_valid;
  logic [9:0]         prod_auto_x, prod_auto_y;
  logic signed [9:0]  prod_cross;
  logic [111:0]       nb_data;
  logic [7:0]         nb_valid;
  logic               act_narrowband;
  logic [12:0]        act_chans;
  logic               cfg_err;
  logic               e_nb = 1'b0;
  int                 e_ch = 0;
  int                 miscompares = 0;
  int                 n_compared = 0;
  int                 cnt_nb[8];
  int                 cnt_wb;

  always #5 clk_sys = ~clk_sys;

  cfbf_digitizer #(.LANES(LANES)) i_dig (
    .clk_sys(clk_sys), .srst(srst), .go(go), .cx(cx), .cy(cy),
    .smp_x(smp_x), .smp_y(smp_y), .smp_valid(smp_valid));

  cfbf_front_end #(.LANES(LANES)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .smp_x(smp_x), .smp_y(smp_y),
    .smp_valid(smp_valid), .walsh_90(walsh_90), .walsh_180(walsh_180),
    .cfg_narrowband(cfg_narrowband), .cfg_full_pol(cfg_full_pol),
    .cfg_nsub_log2(cfg_nsub_log2), .cfg_avg_log2(cfg_avg_log2),
    .cfg_spw_en(cfg_spw_en), .cfg_tune(cfg_tune), .int_boundary(int_boundary),
    .wb_x(wb_x), .wb_y(wb_y), .wb_valid(wb_valid), .prod_auto_x(prod_auto_x),
    .prod_auto_y(prod_auto_y), .prod_cross(prod_cross), .nb_data(nb_data),
    .nb_valid(nb_valid), .act_narrowband(act_narrowband), .act_chans(act_chans),
    .cfg_err(cfg_err));

  // pulse counters, cleared by the tests between edges
  always @(posedge clk_sys) begin
    for (int g = 0; g < 8; g++) begin
      if (nb_valid[g] === 1'b1) cnt_nb[g]++;
    end
    if (wb_valid === 1'b1) cnt_wb++;
  end

  // ==========================================================================
  // tasks
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp

  task automatic clr();
    #1;
    cnt_nb = '{default: 0};
    cnt_wb = 0;
  endtask : clr

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic cfg(input logic nb, fp, input logic [2:0] ns, av, input logic [3:0] en,
                     input logic [15:0] tn, input logic err);
    @(posedge clk_sys);
    int_boundary   <= 1'b1;
    cfg_narrowband <= nb;
    cfg_full_pol   <= fp;
    cfg_nsub_log2  <= ns;
    cfg_avg_log2   <= av;
    cfg_spw_en     <= en;
    cfg_tune       <= {4{tn}};
    @(posedge clk_sys);
    int_boundary <= 1'b0;
    #1;
    if (!err) begin
      e_nb = nb;
      e_ch = nb ? (7680 >> (fp ? 2 : 1) >> (5 - ns) >> av) : (256 >> (fp ? 2 : 1));
    end
    cmp("act_narrowband", 64'(e_nb), 64'(act_narrowband));
    cmp("act_chans", 64'(e_ch), 64'(act_chans));
    cmp("cfg_err", 64'(err), 64'(cfg_err));
  endtask : cfg

  task automatic burst(input int n, input logic [2:0] x, y, input logic w90, w180);
    @(posedge clk_sys);
    go        <= 1'b1;
    cx        <= x;
    cy        <= y;
    walsh_90  <= w90;
    walsh_180 <= w180;
    repeat (n) @(posedge clk_sys);
    go <= 1'b0;
  endtask : burst

  task automatic wb_chk(input logic [2:0] x, y, input logic w90, w180);
    logic [2:0] ex, ey;
    int lx, ly;
    ex = w180 ? ~x : x;
    ey = (w180 ^ w90) ? ~y : y;
    lx = 2 * ex[2:1] - 3;
    ly = 2 * ey[2:1] - 3;
    burst(1, x, y, w90, w180);
    #1;
    for (int k = 0; k < 6 && wb_valid !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp("wb_valid", 64'h1, 64'(wb_valid));
    cmp("wb_x", 64'({LANES{ex[2:1]}}), wb_x);
    cmp("wb_y", 64'({LANES{ey[2:1]}}), wb_y);
    cmp("prod_auto_x", 64'(LANES * lx * lx), 64'(prod_auto_x));
    cmp("prod_auto_y", 64'(LANES * ly * ly), 64'(prod_auto_y));
    cmp("prod_cross", 64'(LANES * lx * ly), 64'(prod_cross));
    @(posedge clk_sys);
    #1;
    cmp("wb_valid pulse", 64'h0, 64'(wb_valid));
  endtask : wb_chk

  // ==========================================================================
  // watchdog
  initial begin
    #200us;
    miscompares++;
    $display("ERROR watchdog expected done seen timeout");
    results();
  end

  // ==========================================================================
  // tests
  initial begin
    logic [3:0] en;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    cfg(1'b0, 1'b0, 3'h0, 3'h0, 4'h0, 16'h0000, 1'b0);
    clr();
    for (int c = 0; c < 8; c++) wb_chk(3'(c), 3'(7 - c), 1'b0, 1'b0);
    wb_chk(3'h1, 3'h6, 1'b0, 1'b1);
    wb_chk(3'h2, 3'h5, 1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    cmp("nb pulses in wideband", 64'h0, 64'(cnt_nb.sum()));
    cfg(1'b0, 1'b1, 3'h0, 3'h0, 4'h0, 16'h0000, 1'b0);
    @(posedge clk_sys);
    ce             <= 1'b0;
    int_boundary   <= 1'b1;
    cfg_narrowband <= 1'b1;
    @(posedge clk_sys);
    int_boundary <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp("act_narrowband frozen", 64'h0, 64'(act_narrowband));
    cmp("act_chans frozen", 64'(e_ch), 64'(act_chans));
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("test wideband done");

    for (int ns = 0; ns < 6; ns++) begin
      cfg(1'b1, 1'b0, 3'(ns), 3'h0, 4'h1, 16'h8000, 1'b0);
      cfg(1'b1, 1'b1, 3'(ns), 3'h1, 4'h1, 16'h8000, 1'b0);
    end
    cfg(1'b1, 1'b0, 3'h6, 3'h0, 4'h1, 16'h8000, 1'b1);
    cfg(1'b1, 1'b0, 3'h0, 3'h5, 4'h1, 16'h8000, 1'b1);
    cfg(1'b1, 1'b0, 3'h0, 3'h0, 4'h1, 16'h03ff, 1'b1);
    cfg(1'b1, 1'b0, 3'h0, 3'h0, 4'h1, 16'hfc01, 1'b1);
    cfg(1'b1, 1'b0, 3'h5, 3'h0, 4'h1, 16'h7fff, 1'b1);
    cfg(1'b1, 1'b0, 3'h0, 3'h0, 4'h1, 16'hfc00, 1'b0);
    @(posedge clk_sys);
    cfg_narrowband <= 1'b0;
    cfg_avg_log2   <= 3'h3;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp("act_narrowband held", 64'h1, 64'(act_narrowband));
    cmp("act_chans held", 64'(e_ch), 64'(act_chans));
    $display("test configuration done");

    for (int a = 0; a < 5; a++) begin
      en = (a == 4) ? 4'hf : (a[0] ? 4'ha : 4'h5);
      cfg(1'b1, 1'b0, 3'h5, 3'(a), en, 16'h8000, 1'b0);
      clr();
      burst(32, 3'h6, 3'h1, 1'b0, 1'b0);
      repeat (6) @(posedge clk_sys);
      for (int g = 0; g < 8; g++) begin
        cmp($sformatf("nb_valid count %0d", g), 64'(en[g/2] ? (32 >> a) : 0), 64'(cnt_nb[g]));
      end
      cmp("wb pulses in narrowband", 64'h0, 64'(cnt_wb));
    end
    cfg(1'b1, 1'b0, 3'h0, 3'h0, 4'h1, 16'h0400, 1'b0);
    burst(1, 3'h6, 3'h1, 1'b0, 1'b0);
    #1;
    for (int k = 0; k < 6 && nb_valid[0] !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    // this tuning word keeps the square-wave oscillator positive on every lane
    cmp("nb_valid 0", 64'h1, 64'(nb_valid[0]));
    cmp("nb_data x", 64'(LANES * 5), 64'($signed(nb_data[13:0])));
    cmp("nb_data y", 64'(-LANES * 5), 64'($signed(nb_data[27:14])));
    $display("test narrowband done");
    results();
  end
endmodule : cfbf_front_end_tb
